// ===== rse_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host side: takes each result byte once it is offered
// ----------------------------------------
module rse_host_model (
	// clock and control
	input wire logic clk,
	input wire logic clear,
	input wire logic [3:0] gap,
	// result read-out
	input wire logic resultValid,
	input wire logic [7:0] resultData,
	input wire logic resultLast,
	output logic resultRead,
	// what was read
	output logic [23:0] bytesSeen,
	output logic [2:0] lastSeen,
	output logic [1:0] readCount
);
	logic [3:0] waitLeft;
	// quiet start so the first request is never unknown
	initial begin
		resultRead = 1'b0;
		readCount = 2'h0;
		waitLeft = 4'h0;
	end
	// capture at the edge that accepts the read; gap models a slow host
	always @(posedge clk) begin
		if (clear) begin
			readCount <= 2'h0;
			waitLeft <= gap;
		end else if (resultRead && resultValid) begin
			bytesSeen[8*readCount +: 8] <= resultData;
			lastSeen[readCount] <= resultLast;
			readCount <= readCount + 2'h1;
			waitLeft <= gap;
		end else if (waitLeft != 4'h0) begin
			waitLeft <= waitLeft - 4'h1;
		end
	end
	// raised on a falling edge, held until a rising edge accepts it
	always @(negedge clk) begin
		resultRead <= (resultValid === 1'b1) && (waitLeft == 4'h0) && !clear;
	end
endmodule // rse_host_model

// ===== rse_pkg.sv
package rse_pkg;
	// termination codes in byte 0 bits 7:6
	localparam logic [1:0] RSE_TERM_NORMAL = 2'h0;
	localparam logic [1:0] RSE_TERM_ABNORMAL = 2'h1;
	localparam logic [1:0] RSE_TERM_INVALID = 2'h2;
	localparam logic [1:0] RSE_TERM_POLLING = 2'h3;
	// byte 0 field positions
	localparam int RSE_B0_TERM_HI = 7;
	localparam int RSE_B0_TERM_LO = 6;
	localparam int RSE_B0_POS_DONE = 5;
	localparam int RSE_B0_EQUIP = 4;
	localparam int RSE_B0_HEAD = 2;
	localparam int RSE_B0_DRV_HI = 1;
	// byte 1 field positions
	localparam int RSE_B1_END_TRACK = 7;
	localparam int RSE_B1_CRC_ANY = 5;
	localparam int RSE_B1_OVERRUN = 4;
	localparam int RSE_B1_SECT_MISS = 2;
	localparam int RSE_B1_WR_BLOCK = 1;
	localparam int RSE_B1_NO_ID = 0;
	// byte 2 field positions
	localparam int RSE_B2_DEL_MISM = 6;
	localparam int RSE_B2_FIELD_CRC = 5;
	localparam int RSE_B2_TRK_MISM = 4;
	localparam int RSE_B2_BAD_TRK = 1;
	localparam int RSE_B2_NO_DATA = 0;
	// constants
	localparam logic [7:0] RSE_BAD_TRACK_ID = 8'hFF;
	localparam logic [7:0] RSE_BYTE_RESET = 8'h00;
	localparam logic [7:0] RSE_LAST_SECTOR = 8'hFF;
	localparam logic [1:0] RSE_INDEX_LIMIT = 2'h2;
	localparam logic [1:0] RSE_IDX_ZERO = 2'h0;
	localparam logic [1:0] RSE_IDX_ONE = 2'h1;
	localparam logic [1:0] RSE_RES_COUNT = 2'h3;
	// command classes seen by the encoder
	typedef enum logic [2:0] {
		RSE_CMD_OTHER = 3'b000,
		RSE_CMD_READ = 3'b001,
		RSE_CMD_READ_DEL = 3'b010,
		RSE_CMD_WRITE = 3'b011,
		RSE_CMD_FORMAT = 3'b100,
		RSE_CMD_READ_ID = 3'b101,
		RSE_CMD_READ_TRACK = 3'b110,
		RSE_CMD_POSITION = 3'b111
	} rse_cmd_e;
	// result read-out states
	typedef enum logic [1:0] {
		RSE_ST_IDLE = 2'b00,
		RSE_ST_EXEC = 2'b01,
		RSE_ST_RESULT = 2'b10
	} rse_state_e;
endpackage

// ===== rse_result_status_encoder.sv
`timescale 1ns/1ns
// Functional notes
// - result bytes 0,1,2 presented one after another through data register
// - byte 0 bits 7:6 hold termination code normal/abnormal/invalid/polling
// - byte 0 bit 5 set when seek, relative seek or recalibrate done
// - byte 0 bit 4 set on track zero failure or outward overstep
// - byte 0 shows head in bit 2 and drive number in 1:0
// - unused bits of all three bytes always read zero
// - byte 1 bit 7 on access to sector 255 or transfer without terminal count
// - byte 1 bit 5 on CRC error in id or data field
// - byte 1 bit 4 on late host or DMA service
// - byte 1 bit 2 when sector, id or sequence not found
// - byte 1 bit 1 when write protect high during write or format
// - byte 1 bit 0 when no id mark after two index pulses, or no data mark
// - byte 2 bit 6 on data mark kind opposite to the read command
// - byte 2 bit 5 on CRC error in data field
// - byte 2 bit 4 when id track differs from internal track
// - byte 2 bit 1 when id track differs and equals FF
// - byte 2 bit 0 when no data or deleted mark found
// - implicit termination reports abnormal termination
module rse_result_status_encoder
	import rse_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// command executor
	input wire logic cmdStart,
	input wire rse_pkg::rse_cmd_e cmdClass,
	input wire logic cmdInvalid,
	input wire logic cmdDone,
	input wire logic pollAbort,
	input wire logic headAddr,
	input wire logic [1:0] driveNumber,
	input wire logic [7:0] internalTrack,
	// executor condition events, one-cycle pulses
	input wire logic recalStepsDone,
	input wire logic relSeekPastZero,
	input wire logic sectorAccess,
	input wire logic [7:0] sectorNumber,
	input wire logic terminalCount,
	input wire logic idCrcFault,
	input wire logic dataCrcFault,
	input wire logic serviceLate,
	input wire logic sectorNotFound,
	input wire logic idReadFault,
	input wire logic sequenceFault,
	input wire logic idMarkSeen,
	input wire logic dataMarkSeen,
	input wire logic deletedMarkSeen,
	input wire logic dataMarkAbsent,
	input wire logic idValid,
	input wire logic [7:0] idTrack,
	// drive pins
	input wire logic trackZeroInput,
	input wire logic writeProtectInput,
	input wire logic rotationPulseInput_n,
	// host result read-out
	input wire logic resultRead,
	output logic resultValid,
	output logic [7:0] resultData,
	output logic resultLast
);
	// ------------------------------------------------------------
	// synchronised drive pins
	// ------------------------------------------------------------
	logic trackZeroSync;
	logic writeProtectSync;
	logic indexSync_n;

	rse_sync uTrackZero (.clk(clk), .reset_n(reset_n), .pinIn(trackZeroInput),
		.pinSync(trackZeroSync));
	rse_sync uWp (.clk(clk), .reset_n(reset_n), .pinIn(writeProtectInput),
		.pinSync(writeProtectSync));
	rse_sync uIdx (.clk(clk), .reset_n(reset_n), .pinIn(rotationPulseInput_n),
		.pinSync(indexSync_n));

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		rse_state_e state;
		logic [1:0] term;
		logic idxPrev_n;
		logic [1:0] idxCount;
		logic idFound;
		logic countSeen;
		logic [1:0] byteSel;
		logic [7:0] data;
	} rse_core_s;
	rse_core_s state_q;
	rse_core_s state_d;

	// ------------------------------------------------------------
	// condition events
	// ------------------------------------------------------------
	localparam int NFLAG = 13;
	logic [NFLAG-1:0] flagSet;
	logic [NFLAG-1:0] flags;
	logic isRead;
	logic isWrite;
	logic indexEdge;
	logic trkDiff;
	logic endNoCount;
	logic anyError;
	logic [NFLAG-1:0] flagsNext;
	logic [1:0] termNext;

	assign isRead = (cmdClass == RSE_CMD_READ) || (cmdClass == RSE_CMD_READ_DEL);
	assign isWrite = (cmdClass == RSE_CMD_WRITE) || (cmdClass == RSE_CMD_FORMAT);
	// index is active low; count its falling edges
	assign indexEdge = state_q.idxPrev_n && !indexSync_n;
	assign trkDiff = idValid && (idTrack != internalTrack);
	// read or write data ended without terminal count
	assign endNoCount = cmdDone && !state_q.countSeen && (state_q.state == RSE_ST_EXEC)
		&& ((cmdClass == RSE_CMD_READ) || (cmdClass == RSE_CMD_WRITE));
	wire execOn = (state_q.state == RSE_ST_EXEC);

	always_comb begin
		flagSet = '0;
		flagSet[0] = execOn && (cmdClass == RSE_CMD_POSITION) && cmdDone;
		flagSet[1] = execOn && ((recalStepsDone && !trackZeroSync)
			|| relSeekPastZero);
		flagSet[2] = execOn && ((sectorAccess && sectorNumber == RSE_LAST_SECTOR)
			|| endNoCount);
		flagSet[3] = execOn && (idCrcFault || dataCrcFault);
		flagSet[4] = execOn && serviceLate;
		flagSet[5] = execOn && ((isRead && sectorNotFound)
			|| (cmdClass == RSE_CMD_READ_ID && idReadFault)
			|| (cmdClass == RSE_CMD_READ_TRACK && sequenceFault));
		flagSet[6] = execOn && isWrite && writeProtectSync;
		flagSet[7] = execOn && ((indexEdge && !state_q.idFound
			&& state_q.idxCount == RSE_IDX_ONE) || dataMarkAbsent);
		flagSet[8] = execOn && ((cmdClass == RSE_CMD_READ && deletedMarkSeen)
			|| (cmdClass == RSE_CMD_READ_DEL && dataMarkSeen));
		flagSet[9] = execOn && dataCrcFault;
		flagSet[10] = execOn && trkDiff;
		flagSet[11] = execOn && trkDiff && idTrack == RSE_BAD_TRACK_ID;
		flagSet[12] = execOn && dataMarkAbsent;
	end

	// one sticky bit per condition, cleared as each command starts
	genvar gi;
	generate
		for (gi = 0; gi < NFLAG; gi++) begin : gFlag
			rse_sticky uFlag (.clk(clk), .reset_n(reset_n), .setIn(flagSet[gi]),
				.clearIn(cmdStart), .flag(flags[gi]));
		end
	endgenerate

	// an error in the final cycle still counts toward the code
	assign anyError = |flags[NFLAG-1:1] || |flagSet[NFLAG-1:1];

	// next flag values: the byte registered at cmdDone must already show
	// events of that same cycle, since the host may take it at once
	assign flagsNext = flagSet | (flags & {NFLAG{!cmdStart}});

	// ending code worked out one edge early for the same reason
	always_comb begin
		termNext = state_q.term;
		if (state_q.state == RSE_ST_IDLE && cmdStart) begin
			termNext = RSE_TERM_NORMAL;
		end else if (execOn && cmdDone) begin
			// invalid beats polling beats errors; overrun and end of
			// track land in the error term, giving abnormal
			if (cmdInvalid) begin
				termNext = RSE_TERM_INVALID;
			end else if (pollAbort) begin
				termNext = RSE_TERM_POLLING;
			end else if (anyError || endNoCount) begin
				termNext = RSE_TERM_ABNORMAL;
			end else begin
				termNext = RSE_TERM_NORMAL;
			end
		end
	end

	// ------------------------------------------------------------
	// byte assembly
	// ------------------------------------------------------------
	logic [7:0] byte0;
	logic [7:0] byte1;
	logic [7:0] byte2;

	// unused positions stay zero by construction
	always_comb begin
		byte0 = RSE_BYTE_RESET;
		byte1 = RSE_BYTE_RESET;
		byte2 = RSE_BYTE_RESET;
		byte0[RSE_B0_TERM_HI:RSE_B0_TERM_LO] = termNext;
		byte0[RSE_B0_POS_DONE] = flagsNext[0];
		byte0[RSE_B0_EQUIP] = flagsNext[1];
		byte0[RSE_B0_HEAD] = headAddr;
		byte0[RSE_B0_DRV_HI:0] = driveNumber;
		byte1[RSE_B1_END_TRACK] = flagsNext[2];
		byte1[RSE_B1_CRC_ANY] = flagsNext[3];
		byte1[RSE_B1_OVERRUN] = flagsNext[4];
		byte1[RSE_B1_SECT_MISS] = flagsNext[5];
		byte1[RSE_B1_WR_BLOCK] = flagsNext[6];
		byte1[RSE_B1_NO_ID] = flagsNext[7];
		byte2[RSE_B2_DEL_MISM] = flagsNext[8];
		byte2[RSE_B2_FIELD_CRC] = flagsNext[9];
		byte2[RSE_B2_TRK_MISM] = flagsNext[10];
		byte2[RSE_B2_BAD_TRK] = flagsNext[11];
		byte2[RSE_B2_NO_DATA] = flagsNext[12];
	end

	function automatic logic [7:0] pickByte(input logic [1:0] sel, input logic [7:0] b0,
		input logic [7:0] b1, input logic [7:0] b2);
		case (sel)
			2'h0: pickByte = b0;
			2'h1: pickByte = b1;
			default: pickByte = b2;
		endcase
	endfunction

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.idxPrev_n = indexSync_n;
		state_d.term = termNext;
		case (state_q.state)
			RSE_ST_IDLE: begin
				if (cmdStart) begin
					state_d.state = RSE_ST_EXEC;
					state_d.idxCount = RSE_IDX_ZERO;
					state_d.idFound = 1'b0;
					state_d.countSeen = 1'b0;
				end
			end
			RSE_ST_EXEC: begin
				if (terminalCount) begin
					state_d.countSeen = 1'b1;
				end
				if (idMarkSeen) begin
					state_d.idFound = 1'b1;
				end
				if (indexEdge && state_q.idxCount != RSE_INDEX_LIMIT) begin
					state_d.idxCount = state_q.idxCount + RSE_IDX_ONE;
				end
				if (cmdDone) begin
					state_d.state = RSE_ST_RESULT;
					state_d.byteSel = 2'h0;
				end
			end
			RSE_ST_RESULT: begin
				if (resultRead) begin
					if (state_q.byteSel == RSE_RES_COUNT - 2'h1) begin
						state_d.state = RSE_ST_IDLE;
					end else begin
						state_d.byteSel = state_q.byteSel + 2'h1;
					end
				end
			end
			default: state_d.state = RSE_ST_IDLE;
		endcase
		// registered read data tracks the selected byte
		state_d.data = pickByte(state_d.byteSel, byte0, byte1, byte2);
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// edge history starts at the synchroniser's reset level: no false index edge
			state_q <= '{state: RSE_ST_IDLE, term: RSE_TERM_NORMAL, idxPrev_n: 1'b0,
				idxCount: RSE_IDX_ZERO, idFound: 1'b0, countSeen: 1'b0, byteSel: 2'h0,
				data: RSE_BYTE_RESET};
		end else begin
			state_q <= state_d;
		end
	end

	assign resultValid = (state_q.state == RSE_ST_RESULT);
	assign resultData = state_q.data;
	assign resultLast = resultValid && (state_q.byteSel == RSE_RES_COUNT - 2'h1);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	unused_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
		resultValid |-> (state_q.byteSel != 2'h0 || !resultData[3]))
		else $error("unused byte 0 bit set");
	byte_order_a: assert property (@(posedge clk) disable iff (!reset_n)
		(resultValid && resultRead && !resultLast) |=>
		(state_q.byteSel == $past(state_q.byteSel) + 2'h1))
		else $error("result bytes out of order");
	term_invalid_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && cmdDone && cmdInvalid) |=> (state_q.term == RSE_TERM_INVALID))
		else $error("invalid command code wrong");
	clear_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdStart && !(|flagSet)) |=> (flags == '0))
		else $error("flags not cleared at start");
	crc_both_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && dataCrcFault && !cmdStart) |=> (flags[9] && flags[3]))
		else $error("data crc not recorded");
	bad_track_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && idValid && idTrack == RSE_BAD_TRACK_ID && internalTrack != RSE_BAD_TRACK_ID
		&& !cmdStart) |=> (flags[11] && flags[10]))
		else $error("bad track not recorded");
	abnormal_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && cmdDone && !cmdInvalid && !pollAbort && flags[4]) |=>
		(state_q.term == RSE_TERM_ABNORMAL))
		else $error("overrun not abnormal");
	write_block_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && isWrite && writeProtectSync && !cmdStart) |=> flags[6])
		else $error("write protect not recorded");
	pos_done_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && cmdDone && cmdClass == RSE_CMD_POSITION) |=> resultData[RSE_B0_POS_DONE])
		else $error("positioning done not shown");
	first_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && cmdDone) |=> (resultData[RSE_B0_TERM_HI:RSE_B0_TERM_LO] == state_q.term))
		else $error("first byte code stale");
	no_data_mark_a: assert property (@(posedge clk) disable iff (!reset_n)
		(execOn && dataMarkAbsent && !cmdStart) |=> (flags[12] && flags[7]))
		else $error("missing data mark not recorded");
endmodule // rse_result_status_encoder

// ===== rse_sticky.sv
`timescale 1ns/1ns
// sticky condition bit: set wins over clear
module rse_sticky (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic setIn,
	input wire logic clearIn,
	output logic flag
);
	typedef struct packed {
		logic flag;
	} rse_sticky_s;
	rse_sticky_s state_q;
	rse_sticky_s state_d;

	// an event landing on the clear cycle is kept
	always_comb begin
		state_d = state_q;
		if (setIn) begin
			state_d.flag = 1'b1;
		end else if (clearIn) begin
			state_d.flag = 1'b0;
		end
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign flag = state_q.flag;
endmodule // rse_sticky

// ===== rse_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for one drive pin
module rse_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pin and result
	input wire logic pinIn,
	output logic pinSync
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} rse_sync_s;
	rse_sync_s state_q;
	rse_sync_s state_d;

	// first stage feeds only the second
	always_comb begin
		state_d = state_q;
		state_d.stage1 = pinIn;
		state_d.stage2 = state_q.stage1;
	end

	// register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pinSync = state_q.stage2;
endmodule // rse_sync

// ===== test_rse_result_status_encoder.sv
`timescale 1ns/1ns
module test_rse_result_status_encoder;
	import rse_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	localparam logic [14:0] EV_COUNT = 15'h0001, EV_RECAL = 15'h0002, EV_RELSEEK = 15'h0004,
		EV_ACCESS = 15'h0008, EV_IDCRC = 15'h0010, EV_DCRC = 15'h0020, EV_LATE = 15'h0040,
		EV_NOSECT = 15'h0080, EV_IDRD = 15'h0100, EV_SEQ = 15'h0200, EV_IDMARK = 15'h0400,
		EV_DMARK = 15'h0800, EV_DELMARK = 15'h1000, EV_NODMARK = 15'h2000, EV_IDV = 15'h4000;
	logic clk = 1'b0;
	logic reset_n, cmdStart, cmdInvalid, cmdDone, pollAbort, headAddr;
	logic trackZeroInput, writeProtectInput, rotationPulseInput_n, hostClear;
	logic [1:0] driveNumber;
	logic [7:0] internalTrack, sectorNumber, idTrack;
	rse_cmd_e cmdClass;
	logic [14:0] evBus;
	logic recalStepsDone, relSeekPastZero, sectorAccess, terminalCount, idCrcFault;
	logic dataCrcFault, serviceLate, sectorNotFound, idReadFault, sequenceFault;
	logic idMarkSeen, dataMarkSeen, deletedMarkSeen, dataMarkAbsent, idValid;
	logic resultRead, resultValid, resultLast;
	logic [7:0] resultData;
	logic [3:0] hostGap;
	logic [23:0] bytesSeen;
	logic [2:0] lastSeen;
	logic [1:0] readCount;
	int fail_count = 0;
	int total_checks = 0;
	// one bus of pulses keeps each event one cycle wide by construction
	assign {idValid, dataMarkAbsent, deletedMarkSeen, dataMarkSeen, idMarkSeen, sequenceFault,
		idReadFault, sectorNotFound, serviceLate, dataCrcFault, idCrcFault, sectorAccess,
		relSeekPastZero, recalStepsDone, terminalCount} = evBus;
	always #5 clk = ~clk;
	// ----------------------------------------
	// design and host
	// ----------------------------------------
	rse_result_status_encoder u_dut (.clk(clk), .reset_n(reset_n), .cmdStart(cmdStart),
		.cmdClass(cmdClass), .cmdInvalid(cmdInvalid), .cmdDone(cmdDone), .pollAbort(pollAbort),
		.headAddr(headAddr), .driveNumber(driveNumber), .internalTrack(internalTrack),
		.recalStepsDone(recalStepsDone), .relSeekPastZero(relSeekPastZero),
		.sectorAccess(sectorAccess), .sectorNumber(sectorNumber), .terminalCount(terminalCount),
		.idCrcFault(idCrcFault), .dataCrcFault(dataCrcFault), .serviceLate(serviceLate),
		.sectorNotFound(sectorNotFound), .idReadFault(idReadFault),
		.sequenceFault(sequenceFault), .idMarkSeen(idMarkSeen), .dataMarkSeen(dataMarkSeen),
		.deletedMarkSeen(deletedMarkSeen), .dataMarkAbsent(dataMarkAbsent), .idValid(idValid),
		.idTrack(idTrack), .trackZeroInput(trackZeroInput),
		.writeProtectInput(writeProtectInput), .rotationPulseInput_n(rotationPulseInput_n),
		.resultRead(resultRead), .resultValid(resultValid), .resultData(resultData),
		.resultLast(resultLast));
	rse_host_model u_host (.clk(clk), .clear(hostClear), .gap(hostGap),
		.resultValid(resultValid), .resultData(resultData), .resultLast(resultLast),
		.resultRead(resultRead), .bytesSeen(bytesSeen), .lastSeen(lastSeen),
		.readCount(readCount));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one whole command: start, events, index pulses, end, three reads, compare
	task automatic run(input rse_cmd_e cls, input logic [14:0] ev, input logic inv,
		input logic poll, input int nIdx, input logic [7:0] e0, e1, e2);
		int i;
		@(negedge clk);
		hostClear = 1'b1;
		cmdStart = 1'b1;
		cmdClass = cls;
		@(negedge clk);
		hostClear = 1'b0;
		cmdStart = 1'b0;
		evBus = ev;
		@(negedge clk);
		evBus = 15'h0000;
		for (i = 0; i < nIdx; i++) begin
			rotationPulseInput_n = 1'b0;
			repeat (3) @(negedge clk);
			rotationPulseInput_n = 1'b1;
			repeat (3) @(negedge clk);
		end
		// let the two-flop pin paths settle before execution ends
		repeat (4) @(negedge clk);
		cmdInvalid = inv;
		pollAbort = poll;
		cmdDone = 1'b1;
		@(negedge clk);
		cmdDone = 1'b0;
		cmdInvalid = 1'b0;
		pollAbort = 1'b0;
		i = 0;
		while (readCount !== 2'h3 && i < 60) begin
			@(negedge clk);
			i++;
		end
		if (i == 60) begin
			fail_count++;
			$display("Error read-out expected 3 bytes seen %0d", readCount);
			stop_test();
		end else begin
			chk8("byte 0", e0, bytesSeen[7:0]);
			chk8("byte 1", e1, bytesSeen[15:8]);
			chk8("byte 2", e2, bytesSeen[23:16]);
			chk8("valid after read-out", 8'h00, {7'h00, resultValid});
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_state;
		chk8("data after reset", RSE_BYTE_RESET, resultData);
		chk8("valid and last after reset", 8'h00, {6'h00, resultValid, resultLast});
		$display("test reset state done");
	endtask
	task automatic t_normal;
		headAddr = 1'b1;
		driveNumber = 2'h2;
		hostGap = 4'h3;
		run(RSE_CMD_READ, EV_COUNT | EV_DMARK, 1'b0, 1'b0, 0, 8'h06, 8'h00, 8'h00);
		chk8("last marks", 8'h04, {5'h00, lastSeen});
		headAddr = 1'b0;
		driveNumber = 2'h1;
		hostGap = 4'h0;
		$display("test normal slow host done");
	endtask
	task automatic t_codes;
		run(RSE_CMD_OTHER, 15'h0000, 1'b1, 1'b0, 0, 8'h81, 8'h00, 8'h00);
		run(RSE_CMD_OTHER, 15'h0000, 1'b0, 1'b1, 0, 8'hC1, 8'h00, 8'h00);
		run(RSE_CMD_OTHER, 15'h0000, 1'b1, 1'b1, 0, 8'h81, 8'h00, 8'h00);
		$display("test termination codes done");
	endtask
	task automatic t_position;
		run(RSE_CMD_POSITION, 15'h0000, 1'b0, 1'b0, 0, 8'h21, 8'h00, 8'h00);
		run(RSE_CMD_POSITION, EV_RECAL, 1'b0, 1'b0, 0, 8'h21, 8'h00, 8'h00);
		run(RSE_CMD_POSITION, EV_RELSEEK, 1'b0, 1'b0, 0, 8'h71, 8'h00, 8'h00);
		trackZeroInput = 1'b0;
		run(RSE_CMD_POSITION, EV_RECAL, 1'b0, 1'b0, 0, 8'h71, 8'h00, 8'h00);
		trackZeroInput = 1'b1;
		$display("test positioning done");
	endtask
	task automatic t_read_errors;
		sectorNumber = 8'hFE;
		run(RSE_CMD_READ, EV_COUNT | EV_ACCESS, 1'b0, 1'b0, 0, 8'h01, 8'h00, 8'h00);
		sectorNumber = 8'hFF;
		idTrack = 8'hFF;
		run(RSE_CMD_READ, EV_COUNT | EV_ACCESS | EV_IDCRC | EV_DCRC | EV_LATE | EV_NOSECT
			| EV_DELMARK | EV_NODMARK | EV_IDV, 1'b0, 1'b0, 0,
			8'h41, 8'hB5, 8'h73);
		run(RSE_CMD_READ, EV_COUNT | EV_IDCRC, 1'b0, 1'b0, 0, 8'h41, 8'h20, 8'h00);
		run(RSE_CMD_OTHER, 15'h0000, 1'b0, 1'b0, 0, 8'h01, 8'h00, 8'h00);
		$display("test read errors done");
	endtask
	task automatic t_term_and_write;
		run(RSE_CMD_READ, 15'h0000, 1'b0, 1'b0, 0, 8'h41, 8'h80, 8'h00);
		run(RSE_CMD_WRITE, 15'h0000, 1'b0, 1'b0, 0, 8'h41, 8'h80, 8'h00);
		writeProtectInput = 1'b1;
		run(RSE_CMD_WRITE, EV_COUNT, 1'b0, 1'b0, 0, 8'h41, 8'h02, 8'h00);
		run(RSE_CMD_FORMAT, 15'h0000, 1'b0, 1'b0, 0, 8'h41, 8'h02, 8'h00);
		run(RSE_CMD_READ, EV_COUNT, 1'b0, 1'b0, 0, 8'h01, 8'h00, 8'h00);
		writeProtectInput = 1'b0;
		$display("test termination and write protect done");
	endtask
	task automatic t_marks;
		idTrack = 8'h07;
		run(RSE_CMD_READ_DEL, EV_DMARK | EV_IDV, 1'b0, 1'b0, 0, 8'h41, 8'h00, 8'h50);
		run(RSE_CMD_READ_ID, 15'h0000, 1'b0, 1'b0, 1, 8'h01, 8'h00, 8'h00);
		run(RSE_CMD_READ_ID, 15'h0000, 1'b0, 1'b0, 2, 8'h41, 8'h01, 8'h00);
		run(RSE_CMD_READ_ID, EV_IDMARK, 1'b0, 1'b0, 2, 8'h01, 8'h00, 8'h00);
		run(RSE_CMD_READ_ID, EV_IDRD, 1'b0, 1'b0, 0, 8'h41, 8'h04, 8'h00);
		run(RSE_CMD_READ_TRACK, EV_SEQ, 1'b0, 1'b0, 0, 8'h41, 8'h04, 8'h00);
		$display("test address marks done");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		{cmdStart, cmdInvalid, cmdDone, pollAbort, headAddr, writeProtectInput} = 6'h00;
		{trackZeroInput, rotationPulseInput_n, hostClear} = 3'h7;
		cmdClass = RSE_CMD_OTHER;
		driveNumber = 2'h1;
		internalTrack = 8'h05;
		sectorNumber = 8'h00;
		idTrack = 8'h05;
		evBus = 15'h0000;
		hostGap = 4'h0;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		t_reset_state();
		t_normal();
		t_codes();
		t_position();
		t_read_errors();
		t_term_and_write();
		t_marks();
		stop_test();
	end
endmodule // test_rse_result_status_encoder
